// ### txe_cfg.svh
// constants of the transmit character encoder: register offsets, reset
// values, code words and sequence counts.
// assumes inclusion by bare name from txe_pkg.sv and txe_encoder.sv.
`ifndef TXE_CFG_SVH
`define TXE_CFG_SVH
// ==========================================================================
// apb register map (byte addresses, one word each)
`define TXE_OFS_CTRL    12'h000
`define TXE_OFS_STATUS  12'h004
`define TXE_OFS_ERR     12'h008
`define TXE_CTRL_ST_BIT 0
`define TXE_RST_CTRL    1'h0
// ==========================================================================
// code words as sent, bit 0 (code bit a) leaves the shifter first
`define TXE_K285_NEG    10'h17c
`define TXE_K285_POS    10'h283
`define TXE_VIOL_POS    10'h079
`define TXE_VIOL_NEG    10'h386
`define TXE_K285_BYTE   8'hbc
`define TXE_SPEC_A_LAST 8'h0b
// word sync sequence: start character plus fifteen, counted 1..15
`define TXE_WS_LAST     4'hf
`define TXE_WS_FIRST    4'h1
`endif

// ### txe_pkg.sv
// types shared by the transmit character encoder.
// assumes txe_cfg.svh is available for inclusion.
`include "txe_cfg.svh"
package txe_pkg;
  // ========================================================================
  // resolved code of a three-level static select pin
  typedef enum logic [1:0] {
    LVL_LOW  = 2'h0,
    LVL_MID  = 2'h1,
    LVL_HIGH = 2'h2
  } txe_lvl_t;
  // word sync sequence state, one per channel
  typedef enum logic [1:0] {
    WS_IDLE = 2'h1,
    WS_RUN  = 2'h2
  } txe_ws_t;
  // character kind chosen by select and control bits
  typedef enum logic [3:0] {
    CK_DATA = 4'h1,
    CK_FILL = 4'h2,
    CK_SPEC = 4'h4,
    CK_SYNC = 4'h8
  } txe_kind_t;
  // whole state of the encoder
  typedef struct packed {
    logic [7:0]        pin_s1;   // static pins, first sync stage
    logic [7:0]        pin_s2;   // static pins, second sync stage
    logic              sel_hold; // select last released by channel a
    logic              st_en;    // self-test enable
    logic [3:0]        rd;       // running disparity, 1 = positive
    txe_ws_t [3:0]     ws;
    logic [3:0][3:0]   ws_cnt;
    logic [3:0][9:0]   out_char;
    logic [3:0]        out_valid;
    logic [3:0]        par_err;
    logic [3:0]        par_sticky;
    logic [3:0]        pha_sticky;
    logic              pready;
    logic              pslverr;
    logic [31:0]       prdata;
  } txe_state_t;
endpackage : txe_pkg

// ### txe_encoder.sv
// four-channel transmit character encoder with mode decode and apb access.
// assumes characters, parity bits and phase-align errors arrive on pclk;
// the static select pins come from outside and are synchronised here.
`timescale 1ns/1ps
`default_nettype none
`include "txe_cfg.svh"
// Notes on behaviour
// - every accepted character yields exactly one 10-bit output character
// - choice uses mode, select, two control bits and eight data bits
// - parity error with checking on emits the violation character
// - phase-align error on a channel emits violation characters instead
// - during self-test the output comes from the test sequence input
// - K28.5 sent alone as fill or within the word sync sequence
// - mode high digit not low encodes characters with 8B/10B
// - special flag uses special code rules, data flag data rules
// - two disjoint special code tables map to the same special set
// - output bit 0 is code bit a and is sent first
// - two three-level pins choose one of nine transmit modes
// - modes 3-8 use control bits as encoder control, table by mode
// - bypass passes the ten captured bits unchanged
// - bypass parity error gives positive violation 1001111000
// - bypass maps data 0-4 a-e, 5 i, 6 f, 7 g, ctl h, j
// - bypass ignores the select; no linkage between channels
// - modes 3/6: ctl0 low data, 01 fill or special, 11 sync
// - per-channel clocks: select from channel a, applied on release
// - encoded violation character carries the current disparity
// - atomic sync runs all sixteen characters, input ignored; a phase-align error still ends the run
module txe_encoder (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire txe_pkg::txe_lvl_t tx_mode_select_hi,
  input  wire txe_pkg::txe_lvl_t tx_mode_select_lo,
  input  wire txe_pkg::txe_lvl_t parity_check_control,
  input  wire txe_pkg::txe_lvl_t tx_input_clock_select,
  input  wire logic              special_char_select,
  input  wire logic [3:0]        char_valid,
  input  wire logic [3:0][7:0]   tx_char_data_bits,
  input  wire logic [3:0][1:0]   tx_char_control_bits,
  input  wire logic [3:0]        tx_char_parity_bits,
  input  wire logic [3:0]        phase_align_error,
  input  wire logic [3:0][9:0]   self_test_char,
  output logic      [3:0][9:0]   tx_char_out,
  output logic      [3:0]        tx_char_out_valid,
  output logic      [3:0]        tx_parity_error
);
  import txe_pkg::*;

  // ========================================================================
  // code tables (negative running disparity forms, abcdei / fghj)
  localparam logic [31:0][5:0] TAB6 = {
    6'b101011, 6'b011110, 6'b101110, 6'b001110,
    6'b110110, 6'b010110, 6'b100110, 6'b110011,
    6'b111010, 6'b011010, 6'b101010, 6'b001011,
    6'b110010, 6'b010011, 6'b100011, 6'b011011,
    6'b010111, 6'b011100, 6'b101100, 6'b001101,
    6'b110100, 6'b010101, 6'b100101, 6'b111001,
    6'b111000, 6'b011001, 6'b101001, 6'b110101,
    6'b110001, 6'b101101, 6'b011101, 6'b100111};
  localparam logic [7:0][3:0] TAB4 = {
    4'b1110, 4'b0110, 4'b1010, 4'b1101,
    4'b1100, 4'b0101, 4'b1001, 4'b1011};

  // 8b/10b encode; returns {next disparity, character with a in bit 0}
  function automatic logic [10:0] enc_char(input logic [7:0] d,
                                           input logic       k,
                                           input logic       rd);
    logic [5:0] six;
    logic [3:0] four;
    logic       rdm;
    logic [9:0] seq;
    logic [9:0] res;
    logic [4:0] x;
    logic [2:0] y;
    x   = d[4:0];
    y   = d[7:5];
    six = (k && x == 5'h1c) ? 6'b001111 : TAB6[x];
    // polarity of the 6b block follows the running disparity
    if (rd && ($countones(six) != 3 || x == 5'h07))
      six = ~six;
    rdm  = rd ^ ($countones(six) != 3);
    four = TAB4[y];
    // alternate x.7 avoids a run of five in the middle of the character
    if (y == 3'h7 && (k || (!rdm && (x == 5'h11 || x == 5'h12 ||
        x == 5'h14)) || (rdm && (x == 5'h0b || x == 5'h0d ||
        x == 5'h0e))))
      four = 4'b0111;
    else if (k && (y == 3'h1 || y == 3'h2 || y == 3'h5 || y == 3'h6))
      four = ~four;
    if (rdm && (k || $countones(four) != 2 || y == 3'h3))
      four = ~four;
    seq = {six, four};
    for (int b = 0; b < 10; b++)
      res[b] = seq[9 - b];
    return {rdm ^ ($countones(four) != 2), res};
  endfunction : enc_char

  // special code lookup over both code sets; returns {known, k byte}
  function automatic logic [8:0] spec_map(input logic [7:0] d);
    logic [8:0] r;
    r = 9'h000;
    if (d <= `TXE_SPEC_A_LAST) begin
      case (d[3:0])
        4'h8:    r = {1'b1, 8'hf7};
        4'h9:    r = {1'b1, 8'hfb};
        4'ha:    r = {1'b1, 8'hfd};
        4'hb:    r = {1'b1, 8'hfe};
        default: r = {1'b1, d[2:0], 5'h1c};
      endcase
    end else if (d[4:0] == 5'h1c || d == 8'hf7 || d == 8'hfb ||
                 d == 8'hfd || d == 8'hfe) begin
      r = {1'b1, d};
    end
    return r;
  endfunction : spec_map

  // odd parity check; returns 1 on error
  function automatic logic par_bad(input logic [7:0] d,
                                   input logic [1:0] c,
                                   input logic       op,
                                   input txe_lvl_t   lvl,
                                   input logic       enc);
    logic bad;
    bad = 1'b0;
    if (lvl == LVL_MID && enc)
      bad = ~^{d, op};
    else if (lvl != LVL_LOW)
      bad = ~^{d, c, op};
    return bad;
  endfunction : par_bad

  function automatic logic addr_is(input logic [11:0] a,
                                   input logic [11:0] ofs);
    return a == ofs;
  endfunction : addr_is

  // ========================================================================
  // state and working signals
  txe_state_t       st_q;
  txe_state_t       st_d;
  txe_lvl_t         m_hi;
  txe_lvl_t         m_lo;
  txe_lvl_t         m_par;
  txe_lvl_t         m_ck;
  logic             bypass;
  logic             sel_eff;
  logic [3:0]       perr;
  logic [3:0]       use_enc;
  logic [3:0]       enc_k;
  logic [3:0][7:0]  enc_byte;
  logic [3:0][10:0] enc_res;
  logic [8:0]       sm;
  logic [1:0]       ct;
  txe_kind_t        kind;
  logic             apb_acc;
  logic [3:0]       err_clr;

  // ========================================================================
  // next-state logic
  always_comb begin
    st_d      = st_q;
    use_enc   = '0;
    enc_k     = '0;
    enc_byte  = '0;
    enc_res   = '0;
    sm        = '0;
    ct        = '0;
    kind      = CK_DATA;
    err_clr   = '0;
    // three-level pins come from outside: two stages before use
    st_d.pin_s1 = {tx_input_clock_select, parity_check_control,
                   tx_mode_select_lo, tx_mode_select_hi};
    st_d.pin_s2 = st_q.pin_s1;
    m_hi   = txe_lvl_t'(st_q.pin_s2[1:0]);
    m_lo   = txe_lvl_t'(st_q.pin_s2[3:2]);
    m_par  = txe_lvl_t'(st_q.pin_s2[5:4]);
    m_ck   = txe_lvl_t'(st_q.pin_s2[7:6]);
    // modes 1 and 2 behave as bypass so a test setting stays harmless
    bypass = (m_hi == LVL_LOW);
    st_d.out_valid = '0;
    st_d.par_err   = '0;
    for (int i = 0; i < 4; i++)
      perr[i] = char_valid[i] & par_bad(tx_char_data_bits[i],
                tx_char_control_bits[i], tx_char_parity_bits[i], m_par,
                !bypass);
    // independent input clocks: channel a releases the select for all
    sel_eff = st_q.sel_hold;
    if (m_ck != LVL_MID)
      sel_eff = special_char_select;
    else if (char_valid[0] && !perr[0] && !phase_align_error[0]) begin
      sel_eff       = special_char_select;
      st_d.sel_hold = special_char_select;
    end
    // per-channel character path, one output per accepted input
    for (int i = 0; i < 4; i++) begin
      ct = tx_char_control_bits[i];
      // character kind from select and control bits
      case (m_lo)
        LVL_LOW:
          kind = !ct[0] ? CK_DATA : ct[1] ? CK_SYNC :
                 sel_eff ? CK_SPEC : CK_FILL;
        LVL_MID:
          kind = !ct[0] ? CK_DATA : sel_eff ? CK_SYNC :
                 ct[1] ? CK_SPEC : CK_FILL;
        default:
          kind = (ct == 2'h0) ? CK_DATA : (ct == 2'h1) ? CK_FILL :
                 (ct == 2'h2) ? CK_SPEC : CK_SYNC;
      endcase
      if (char_valid[i]) begin
        st_d.out_valid[i] = 1'b1;
        st_d.par_err[i]   = perr[i];
        if (st_q.st_en) begin
          st_d.out_char[i] = self_test_char[i];
        end else if (phase_align_error[i]) begin
          st_d.ws[i]       = WS_IDLE;
          st_d.out_char[i] = (bypass || !st_q.rd[i]) ?
                             `TXE_VIOL_POS : `TXE_VIOL_NEG;
        end else if (bypass) begin
          st_d.ws[i]       = WS_IDLE;
          // select ignored, bits pass in weight order
          st_d.out_char[i] = perr[i] ? `TXE_VIOL_POS :
                             {ct, tx_char_data_bits[i]};
        end else if (st_q.ws[i] == WS_RUN && (m_hi == LVL_MID ||
                     (ct == 2'h0 && !perr[i]))) begin
          // atomic run ignores the input and skips the parity check
          st_d.par_err[i] = (m_hi == LVL_MID) ? 1'b0 : perr[i];
          use_enc[i]      = 1'b1;
          enc_k[i]        = 1'b1;
          enc_byte[i]     = `TXE_K285_BYTE;
          st_d.ws_cnt[i]  = st_q.ws_cnt[i] + 4'h1;
          if (st_q.ws_cnt[i] == `TXE_WS_LAST) begin
            st_d.ws[i]     = WS_IDLE;
            st_d.ws_cnt[i] = 4'h0;
          end
        end else begin
          // any break of an interruptible run ends the sequence
          st_d.ws[i]     = WS_IDLE;
          st_d.ws_cnt[i] = 4'h0;
          if (perr[i]) begin
            st_d.out_char[i] = st_q.rd[i] ?
                               `TXE_VIOL_NEG : `TXE_VIOL_POS;
          end else begin
            use_enc[i] = 1'b1;
            case (kind)
              CK_DATA: enc_byte[i] = tx_char_data_bits[i];
              CK_FILL: begin
                enc_k[i]    = 1'b1;
                enc_byte[i] = `TXE_K285_BYTE;
              end
              CK_SPEC: begin
                sm          = spec_map(tx_char_data_bits[i]);
                use_enc[i]  = sm[8];
                enc_k[i]    = 1'b1;
                enc_byte[i] = sm[7:0];
                if (!sm[8])
                  st_d.out_char[i] = st_q.rd[i] ?
                                     `TXE_VIOL_NEG : `TXE_VIOL_POS;
              end
              CK_SYNC: begin
                enc_k[i]       = 1'b1;
                enc_byte[i]    = `TXE_K285_BYTE;
                st_d.ws[i]     = WS_RUN;
                st_d.ws_cnt[i] = `TXE_WS_FIRST;
              end
              default: use_enc[i] = 1'b0;
            endcase
          end
        end
        // encoded characters advance the running disparity
        if (use_enc[i]) begin
          enc_res[i]       = enc_char(enc_byte[i], enc_k[i], st_q.rd[i]);
          st_d.out_char[i] = enc_res[i][9:0];
          st_d.rd[i]       = enc_res[i][10];
        end
      end
    end
    // apb slave: access phase takes two cycles, pready registered
    apb_acc      = psel & penable & ~st_q.pready;
    st_d.pready  = apb_acc;
    st_d.pslverr = 1'b0;
    if (apb_acc) begin
      st_d.prdata  = 32'h0;
      st_d.pslverr = !(addr_is(paddr, `TXE_OFS_CTRL) ||
                       addr_is(paddr, `TXE_OFS_STATUS) ||
                       addr_is(paddr, `TXE_OFS_ERR));
      if (!pwrite) begin
        if (addr_is(paddr, `TXE_OFS_CTRL))
          st_d.prdata[`TXE_CTRL_ST_BIT] = st_q.st_en;
        if (addr_is(paddr, `TXE_OFS_STATUS))
          for (int i = 0; i < 4; i++)
            st_d.prdata[{3'h0, i[1:0]} + 5'h04] = (st_q.ws[i] == WS_RUN);
        if (addr_is(paddr, `TXE_OFS_STATUS))
          st_d.prdata[3:0] = st_q.rd;
        if (addr_is(paddr, `TXE_OFS_ERR))
          st_d.prdata[7:0] = {st_q.pha_sticky, st_q.par_sticky};
      end
    end
    // writes land on the edge that completes the access
    if (psel && penable && st_q.pready && pwrite) begin
      if (addr_is(paddr, `TXE_OFS_CTRL))
        st_d.st_en = pwdata[`TXE_CTRL_ST_BIT];
      if (addr_is(paddr, `TXE_OFS_ERR))
        err_clr = pwdata[3:0];
    end
    // write-one-to-clear; a new error in the same cycle wins
    st_d.par_sticky = (st_q.par_sticky & ~err_clr) | perr;
    st_d.pha_sticky = (st_q.pha_sticky & ~(psel && penable && st_q.pready
                      && pwrite && addr_is(paddr, `TXE_OFS_ERR) ?
                      pwdata[7:4] : 4'h0)) | phase_align_error;
  end

  // ========================================================================
  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q          <= '0;
      st_q.st_en    <= `TXE_RST_CTRL;
      st_q.ws       <= {WS_IDLE, WS_IDLE, WS_IDLE, WS_IDLE};
    end else begin
      st_q <= st_d;
    end
  end

  // outputs straight from the state register
  assign prdata            = st_q.prdata;
  assign pready            = st_q.pready;
  assign pslverr           = st_q.pslverr;
  assign tx_char_out       = st_q.out_char;
  assign tx_char_out_valid = st_q.out_valid;
  assign tx_parity_error   = st_q.par_err;

  // ========================================================================
  // checks on channel a
  logic [9:0] raw_a;
  logic       k285_a;
  assign raw_a  = {tx_char_control_bits[0], tx_char_data_bits[0]};
  assign k285_a = (tx_char_out[0] == `TXE_K285_NEG) ||
                  (tx_char_out[0] == `TXE_K285_POS);

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  one_char_out_a: assert property (
    char_valid[0] |=> tx_char_out_valid[0])
    else $error("accepted character produced no output");
  no_char_idle_a: assert property (
    !char_valid[0] |=> !tx_char_out_valid[0])
    else $error("output character without input");
  bypass_pass_a: assert property (
    (bypass && !st_q.st_en && char_valid[0] && !perr[0] &&
     !phase_align_error[0]) |=> tx_char_out[0] == $past(raw_a))
    else $error("bypass changed the character");
  bypass_viol_a: assert property (
    (bypass && !st_q.st_en && char_valid[0] && perr[0] &&
     !phase_align_error[0]) |=> tx_char_out[0] == `TXE_VIOL_POS)
    else $error("bypass parity error not replaced");
  phase_viol_a: assert property (
    (!st_q.st_en && char_valid[0] && phase_align_error[0]) |=>
    (tx_char_out[0] == `TXE_VIOL_POS || tx_char_out[0] == `TXE_VIOL_NEG))
    else $error("phase error did not force violation");
  self_test_a: assert property (
    (st_q.st_en && char_valid[0]) |=>
    tx_char_out[0] == $past(self_test_char[0]))
    else $error("self-test character not forwarded");
  atomic_sync_a: assert property (
    (!bypass && m_hi == LVL_MID && !st_q.st_en && char_valid[0] &&
     !phase_align_error[0] && st_q.ws[0] == WS_RUN) |=> k285_a)
    else $error("atomic sequence broken by input");
  sync_start_a: assert property (
    (m_hi == LVL_MID && m_lo == LVL_LOW && !st_q.st_en &&
     char_valid[0] && !phase_align_error[0] && !perr[0] &&
     st_q.ws[0] == WS_IDLE && tx_char_control_bits[0] == 2'h3) |=>
    k285_a && st_q.ws[0] == WS_RUN && st_q.ws_cnt[0] == 4'h1)
    else $error("control 11 did not start the sequence");
  disparity_a: assert property (
    $changed(st_q.rd[0]) |->
    tx_char_out_valid[0] && $countones(tx_char_out[0]) != 5)
    else $error("disparity moved without unbalanced character");
  enc_viol_a: assert property (
    (!bypass && !st_q.st_en && char_valid[0] && perr[0] &&
     !phase_align_error[0] && m_hi == LVL_HIGH) |=>
    tx_char_out[0] == ($past(st_q.rd[0]) ? `TXE_VIOL_NEG : `TXE_VIOL_POS))
    else $error("violation character with wrong disparity");

  sync_seen_c: cover property (
    st_q.ws[0] == WS_RUN && st_q.ws_cnt[0] == `TXE_WS_LAST);
  viol_seen_c: cover property (
    tx_parity_error[0] && !bypass);
  bypass_seen_c: cover property (
    bypass && tx_char_out_valid[0]);

endmodule : txe_encoder
`default_nettype wire

// ### txe_host_model.sv
// host logic model: offers one character on all four channels per call.
// assumes the caller waits for the encoder's answer itself.
`timescale 1ns/1ps
`default_nettype none
module txe_host_model (
  input  wire logic            pclk,
  output logic      [3:0]      char_valid,
  output logic      [3:0][7:0] tx_char_data_bits,
  output logic      [3:0][1:0] tx_char_control_bits,
  output logic      [3:0]      tx_char_parity_bits
);
  // ========================================================================
  // idle lines show inverted data so a stale character never looks fresh
  initial begin
    char_valid = 4'h0;
    tx_char_data_bits = '0;
    tx_char_control_bits = '0;
    tx_char_parity_bits = 4'h0;
  end
  task automatic put(input logic [3:0][7:0] d, input logic [1:0] c,
                     input logic [3:0] p);
    @(posedge pclk);
    char_valid <= 4'hf;
    tx_char_data_bits <= d;
    tx_char_control_bits <= {4{c}};
    tx_char_parity_bits <= p;
    @(posedge pclk);
    char_valid <= 4'h0;
    tx_char_data_bits <= ~d;
    tx_char_control_bits <= ~{4{c}};
  endtask : put
endmodule : txe_host_model
`default_nettype wire

// ### tx_char_encoder_mode_select_test.sv
// self-checking bench of the transmit character encoder.
// assumes txe_pkg, txe_encoder and txe_host_model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "txe_cfg.svh"
module tx_char_encoder_mode_select_test;
  import txe_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pready, pslverr, sel = 1'b0, ev;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rv;
  txe_lvl_t m_hi = LVL_LOW, m_lo = LVL_LOW, par = LVL_MID, ck = LVL_LOW;
  logic [3:0] cv, hp, pha = 4'h0, ov, perr, rd = 4'h0, bad;
  logic [3:0][7:0] hd, dat;
  logic [3:0][1:0] hc;
  logic [1:0] c;
  logic [3:0][9:0] st = '0, out, e;
  int num_errors = 0, total_checks = 0, cyc = 0;
  always #2 pclk = ~pclk;
  txe_host_model i_txe_host_model (.pclk(pclk), .char_valid(cv),
    .tx_char_data_bits(hd), .tx_char_control_bits(hc),
    .tx_char_parity_bits(hp));
  txe_encoder i_txe_encoder (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tx_mode_select_hi(m_hi), .tx_mode_select_lo(m_lo),
    .parity_check_control(par), .tx_input_clock_select(ck),
    .special_char_select(sel), .char_valid(cv), .tx_char_data_bits(hd),
    .tx_char_control_bits(hc), .tx_char_parity_bits(hp),
    .phase_align_error(pha), .self_test_char(st), .tx_char_out(out),
    .tx_char_out_valid(ov), .tx_parity_error(perr));
  // ========================================================================
  // checking and bus helpers
  task automatic results();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : results
  task automatic chk(input logic ok, input string m);
    total_checks++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask : chk
  // waits on pready without a fixed latency; the timeout ends a hang
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] wd);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rv = prdata;
    ev = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb
  task automatic mode(input txe_lvl_t h, l, p);
    @(posedge pclk);
    {m_hi, m_lo, par} <= {h, l, p};
    repeat (4) @(posedge pclk);
  endtask : mode
  function automatic logic [9:0] kc(int i);
    kc = rd[i] ? `TXE_K285_POS : `TXE_K285_NEG;
    rd[i] = ~rd[i];
  endfunction : kc
  function automatic logic [9:0] vc(int i);
    vc = rd[i] ? `TXE_VIOL_NEG : `TXE_VIOL_POS;
  endfunction : vc
  // odd parity over data and control, flipped where bad is set
  task automatic chr(input logic [3:0] pe);
    logic [3:0] p;
    for (int i = 0; i < 4; i++) p[i] = ~(^dat[i] ^ ^c) ^ bad[i];
    i_txe_host_model.put(dat, c, p);
    // the output valid stands one cycle only: look at it while it stands
    #1;
    chk(ov === 4'hf && out === e && perr === pe, "character out");
    // return on an edge so that following stimulus lands on it
    @(posedge pclk);
  endtask : chr
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      num_errors++;
      results();
    end
  end
  // ========================================================================
  // main sequence; test modes 1 and 2 are never selected
  initial begin
    void'($urandom(80));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `TXE_OFS_CTRL, 0);
    chk(rv === 32'h0 && ev === 1'b0, "ctrl reset");
    apb(1'b0, 12'h0fc, 0);
    chk(ev === 1'b1, "unmapped");
    repeat (20) begin
      c = $urandom;
      bad = $urandom;
      sel <= $urandom;
      for (int i = 0; i < 4; i++) dat[i] = $urandom;
      for (int i = 0; i < 4; i++) e[i] = bad[i] ? 10'h079 : {c, dat[i]};
      chr(bad);
    end
    mode(LVL_LOW, LVL_LOW, LVL_LOW);
    bad = 4'hf;
    for (int i = 0; i < 4; i++) e[i] = {c, dat[i]};
    chr(4'h0);
    mode(LVL_MID, LVL_LOW, LVL_HIGH);
    // bypass parity errors left sticky bits behind: clear them first
    apb(1'b1, `TXE_OFS_ERR, 32'hff);
    apb(1'b0, `TXE_OFS_ERR, 0);
    chk(rv[7:0] === 8'h00, "sticky clear");
    sel <= 1'b0;
    c = 2'b01;
    bad = 4'h0;
    repeat (3) begin
      for (int i = 0; i < 4; i++) e[i] = kc(i);
      chr(4'h0);
    end
    bad = 4'h5;
    for (int i = 0; i < 4; i++) e[i] = bad[i] ? vc(i) : kc(i);
    chr(4'h5);
    bad = 4'h0;
    pha <= 4'h4;
    for (int i = 0; i < 4; i++) e[i] = (i == 2) ? vc(i) : kc(i);
    chr(4'h0);
    pha <= 4'h0;
    apb(1'b0, `TXE_OFS_STATUS, 0);
    chk(rv[7:0] === {4'h0, rd}, "status");
    apb(1'b0, `TXE_OFS_ERR, 0);
    chk(rv[7:0] === 8'h45, "sticky errors");
    // per-channel clocks: a bad channel a char keeps the held select
    ck <= LVL_MID;
    mode(LVL_MID, LVL_LOW, LVL_HIGH);
    {c, dat, bad} = {2'b01, 32'h0, 4'h0};
    for (int i = 0; i < 4; i++) e[i] = kc(i);
    chr(4'h0);
    sel <= 1'b1;
    bad = 4'h1;
    for (int i = 0; i < 4; i++) e[i] = bad[i] ? vc(i) : kc(i);
    chr(4'h1);
    sel <= 1'b0;
    ck <= LVL_LOW;
    for (int n = 0; n < 16; n++) begin
      if (n == 0) mode(LVL_MID, LVL_HIGH, LVL_HIGH);
      c = (n == 0) ? 2'b11 : 2'($urandom);
      bad = (n == 0) ? 4'h0 : 4'($urandom);
      for (int i = 0; i < 4; i++) e[i] = kc(i);
      chr(4'h0);
    end
    mode(LVL_HIGH, LVL_LOW, LVL_HIGH);
    bad = 4'h0;
    for (int n = 0; n < 3; n++) begin
      c = (n == 0) ? 2'b11 : {1'b0, n == 2};
      for (int i = 0; i < 4; i++) e[i] = kc(i);
      chr(4'h0);
      apb(1'b0, `TXE_OFS_STATUS, 0);
      chk(rv[7:4] === ((n < 2) ? 4'hf : 4'h0), "sync run");
    end
    apb(1'b1, `TXE_OFS_CTRL, 1);
    for (int i = 0; i < 4; i++) e[i] = 10'($urandom);
    st <= e;
    chr(4'h0);
    results();
  end
endmodule : tx_char_encoder_mode_select_test
`default_nettype wire
